// ---- src/two_wire_slave_pkg.sv ----
`default_nettype none
package two_wire_slave_pkg;

    // Register word indices on the Avalon bus (byte address = index * 4)
    localparam logic [2:0] IDX_OWN_ADDR = 3'h0;
    localparam logic [2:0] IDX_CONTROL = 3'h1;
    localparam logic [2:0] IDX_STATUS = 3'h2;
    localparam logic [2:0] IDX_DATA = 3'h3;
    localparam logic [2:0] IDX_SLEEP = 3'h4;

    // serial_control bit positions
    localparam int CTRL_IRQ_FLAG = 7;
    localparam int CTRL_ACK_ENABLE = 6;
    localparam int CTRL_START_REQ = 5;
    localparam int CTRL_STOP_REQ = 4;
    localparam int CTRL_WRITE_COLL = 3;
    localparam int CTRL_IFACE_EN = 2;
    localparam int CTRL_IRQ_EN = 0;

    // own_slave_address layout
    localparam int OWN_GCE_BIT = 0;
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;

    // Status codes, prescaler bits zero
    localparam logic [7:0] ST_OWN_READ = 8'ha8;
    localparam logic [7:0] ST_ARB_READ = 8'hb0;
    localparam logic [7:0] ST_DATA_ACK = 8'hb8;
    localparam logic [7:0] ST_DATA_NACK = 8'hc0;
    localparam logic [7:0] ST_LAST_ACK = 8'hc8;
    localparam logic [7:0] ST_NO_INFO = 8'hf8;
    localparam logic [7:0] STATUS_CODE_MASK = 8'hf8;
    localparam logic [7:0] STATUS_PRESCALE_MASK = 8'h03;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int MSB_BIT = 7;

    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_ADDR,
        LINK_ADDR_ACK,
        LINK_WAIT,
        LINK_TX,
        LINK_TX_ACK,
        LINK_TX_ACK_END,
        LINK_IGNORE
    } link_state_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [2:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avalon_req_type;

endpackage : two_wire_slave_pkg
`default_nettype wire

// ---- src/two_wire_slave_transmitter.sv ----
// Notes on behaviour
// - Answer as slave only to the seven-bit address in own address bits 7:1.
// - With general call enable set, also answer address zero, else ignore.
// - Address match with read bit enters slave transmit, else slave receive; here a write-bit address is ignored (LINK_IGNORE).
// - Own address read acknowledged: set flag, report status A8.
// - Arbitration lost then addressed for read: ack, flag, status B0.
// - Data byte sent and acknowledged: set flag, report status B8.
// - Flag cleared with ack enable one: send byte, expect acknowledge.
// - Flag cleared with ack enable zero: send final byte, expect NACK.
// - Master does not acknowledge a byte: set flag, report status C0.
// - Master acknowledges the final byte: set flag, report status C8.
// - After final byte go unaddressed, ignore master, release the data line.
// - Clearing flag in C0 or C8: ack enable selects address recognition.
// - Start request set on that clear: issue START once the bus is free.
// - Ack enable zero: ignore own address, keep watching, resume when set.
// - In deep sleep with ack enabled: recognise address, wake, hold clock.
// - After wake the clock stays low until software clears the flag.
// - After wake the data register need not hold the last bus byte.
// - Status reads F8 whenever the interrupt flag is clear.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_transmitter (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire two_wire_slave_pkg::avalon_req_type AVS_REQ,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic ARB_LOST,
    output logic START_ISSUE,
    output logic WAKE_REQUEST
);
    import two_wire_slave_pkg::*;

    typedef struct packed {
        logic [7:0] own_addr;
        logic irq_flag;
        logic ack_enable;
        logic start_request;
        logic stop_request;
        logic write_collision;
        logic iface_enable;
        logic irq_enable;
        logic [7:0] prescale;
        logic [7:0] data;
        logic deep_sleep;
        logic [7:0] code;
        link_state_type state;
        logic [7:0] shift;
        logic [2:0] cnt;
        logic last;
        logic acking;
        logic ack_seen;
        logic scl_oe;
        logic sda_oe;
        logic line_level;
        logic busy;
        logic start_pending;
        logic start_issue;
        logic wake;
        logic scl_s1;
        logic scl_s2;
        logic scl_prev;
        logic sda_s1;
        logic sda_s2;
        logic sda_prev;
        logic waitreq;
        logic [31:0] readdata;
    } state_type;

    state_type s;
    state_type next_s;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    function automatic logic addr_match(input logic [6:0] addr,
                                        input logic [7:0] own,
                                        input logic ack_en);
        logic own_hit;
        logic gc_hit;
        own_hit = (addr == own[7:1]);
        gc_hit = (addr == GENERAL_CALL_ADDR) && own[OWN_GCE_BIT];
        addr_match = ack_en && (own_hit || gc_hit);
    endfunction : addr_match

    function automatic logic [7:0] control_view(input state_type r);
        logic [7:0] v;
        v = RESET_BYTE;
        v[CTRL_IRQ_FLAG] = r.irq_flag;
        v[CTRL_ACK_ENABLE] = r.ack_enable;
        v[CTRL_START_REQ] = r.start_request;
        v[CTRL_STOP_REQ] = r.stop_request;
        v[CTRL_WRITE_COLL] = r.write_collision;
        v[CTRL_IFACE_EN] = r.iface_enable;
        v[CTRL_IRQ_EN] = r.irq_enable;
        control_view = v;
    endfunction : control_view

    function automatic logic [7:0] status_view(input state_type r);
        logic [7:0] c;
        c = r.irq_flag ? r.code : ST_NO_INFO;
        status_view = (c & STATUS_CODE_MASK) | r.prescale;
    endfunction : status_view

    function automatic logic [7:0] reg_read(input state_type r,
                                            input logic [2:0] idx);
        case (idx)
            IDX_OWN_ADDR: reg_read = r.own_addr;
            IDX_CONTROL: reg_read = control_view(r);
            IDX_STATUS: reg_read = status_view(r);
            IDX_DATA: reg_read = r.data;
            IDX_SLEEP: reg_read = {7'h00, r.deep_sleep};
            default: reg_read = RESET_BYTE;
        endcase
    endfunction : reg_read

    // Edges come from the second synchroniser stage and its delayed copy only
    assign scl_rise = s.scl_s2 & ~s.scl_prev;
    assign scl_fall = ~s.scl_s2 & s.scl_prev;
    assign start_cond = s.scl_s2 & s.scl_prev & ~s.sda_s2 & s.sda_prev;
    assign stop_cond = s.scl_s2 & s.scl_prev & s.sda_s2 & ~s.sda_prev;

    always_comb begin
        next_s = s;
        next_s.start_issue = 1'b0;
        next_s.wake = 1'b0;
        next_s.scl_s1 = SCL_IN;
        next_s.scl_s2 = s.scl_s1;
        next_s.scl_prev = s.scl_s2;
        next_s.sda_s1 = SDA_IN;
        next_s.sda_s2 = s.sda_s1;
        next_s.sda_prev = s.sda_s2;

        // Bus slave: one wait cycle, then complete at the edge with wait low
        next_s.waitreq = 1'b1;
        if (AVS_REQ.read || AVS_REQ.write) begin
            if (s.waitreq) begin
                next_s.waitreq = 1'b0;
                next_s.readdata = {24'h000000, reg_read(s, AVS_REQ.address)};
            end else if (AVS_REQ.write && AVS_REQ.byteenable[0]) begin
                case (AVS_REQ.address)
                    IDX_OWN_ADDR: next_s.own_addr = AVS_REQ.writedata[7:0];
                    IDX_CONTROL: begin
                        next_s.ack_enable = AVS_REQ.writedata[CTRL_ACK_ENABLE];
                        next_s.start_request = AVS_REQ.writedata[CTRL_START_REQ];
                        next_s.stop_request = AVS_REQ.writedata[CTRL_STOP_REQ];
                        next_s.iface_enable = AVS_REQ.writedata[CTRL_IFACE_EN];
                        next_s.irq_enable = AVS_REQ.writedata[CTRL_IRQ_EN];
                        // Write one clears the flag; hardware sets below win
                        if (AVS_REQ.writedata[CTRL_IRQ_FLAG]) begin
                            next_s.irq_flag = 1'b0;
                        end
                    end
                    IDX_STATUS: next_s.prescale =
                        AVS_REQ.writedata[7:0] & STATUS_PRESCALE_MASK;
                    IDX_DATA: begin
                        // Data is only writable while the link is stalled
                        if (s.irq_flag) begin
                            next_s.data = AVS_REQ.writedata[7:0];
                            next_s.write_collision = 1'b0;
                        end else begin
                            next_s.write_collision = 1'b1;
                        end
                    end
                    IDX_SLEEP: next_s.deep_sleep = AVS_REQ.writedata[0];
                    default: ;
                endcase
            end
        end

        if (s.start_pending && !s.busy) begin
            next_s.start_issue = 1'b1;
            next_s.start_pending = 1'b0;
        end

        if (!s.iface_enable) begin
            next_s.state = LINK_IDLE;
            next_s.scl_oe = 1'b0;
            next_s.sda_oe = 1'b0;
            next_s.busy = 1'b0;
        end else if (start_cond) begin
            // Bus keeps being watched even with acknowledge disabled
            next_s.busy = 1'b1;
            next_s.state = LINK_ADDR;
            next_s.cnt = 3'h0;
            next_s.sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_s.busy = 1'b0;
            next_s.state = LINK_IDLE;
            next_s.sda_oe = 1'b0;
        end else begin
            case (s.state)
                LINK_IDLE: ;
                LINK_IGNORE: next_s.sda_oe = 1'b0;
                LINK_ADDR: begin
                    if (scl_rise) begin
                        next_s.shift = {s.shift[6:0], s.sda_s2};
                        next_s.cnt = s.cnt + 3'h1;
                        if (s.cnt == LAST_BIT) begin
                            // Write direction belongs to the receiver side
                            if (addr_match(s.shift[6:0], s.own_addr,
                                           s.ack_enable) && s.sda_s2) begin
                                next_s.state = LINK_ADDR_ACK;
                                next_s.acking = 1'b0;
                            end else begin
                                next_s.state = LINK_IGNORE;
                            end
                        end
                    end
                end
                LINK_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (!s.acking) begin
                            next_s.acking = 1'b1;
                            next_s.sda_oe = 1'b1;
                        end else begin
                            next_s.sda_oe = 1'b0;
                            next_s.irq_flag = 1'b1;
                            next_s.code = ARB_LOST ? ST_ARB_READ
                                                   : ST_OWN_READ;
                            next_s.scl_oe = 1'b1;
                            next_s.state = LINK_WAIT;
                            if (s.deep_sleep) begin
                                // Clock held across wake-up; data left as is
                                next_s.wake = 1'b1;
                                next_s.deep_sleep = 1'b0;
                            end
                        end
                    end
                end
                LINK_WAIT: begin
                    if (!s.irq_flag) begin
                        next_s.scl_oe = 1'b0;
                        if (s.code == ST_DATA_NACK
                            || s.code == ST_LAST_ACK) begin
                            // Recognition follows ack_enable at the next START
                            next_s.state = LINK_IGNORE;
                            if (s.start_request) begin
                                next_s.start_pending = 1'b1;
                            end
                        end else begin
                            next_s.shift = s.data;
                            next_s.last = !s.ack_enable;
                            next_s.cnt = 3'h0;
                            next_s.sda_oe = !s.data[MSB_BIT];
                            next_s.state = LINK_TX;
                        end
                    end
                end
                LINK_TX: begin
                    if (scl_fall) begin
                        if (s.cnt == LAST_BIT) begin
                            next_s.sda_oe = 1'b0;
                            next_s.state = LINK_TX_ACK;
                        end else begin
                            next_s.cnt = s.cnt + 3'h1;
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.sda_oe = !s.shift[MSB_BIT - 1];
                        end
                    end
                end
                LINK_TX_ACK: begin
                    if (scl_rise) begin
                        next_s.ack_seen = !s.sda_s2;
                        next_s.state = LINK_TX_ACK_END;
                    end
                end
                LINK_TX_ACK_END: begin
                    if (scl_fall) begin
                        next_s.irq_flag = 1'b1;
                        next_s.scl_oe = 1'b1;
                        next_s.state = LINK_WAIT;
                        if (!s.ack_seen) begin
                            next_s.code = ST_DATA_NACK;
                        end else if (s.last) begin
                            next_s.code = ST_LAST_ACK;
                        end else begin
                            next_s.code = ST_DATA_ACK;
                        end
                    end
                end
                default: next_s.state = LINK_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            s <= '{own_addr: RESET_BYTE, code: ST_NO_INFO,
                   prescale: RESET_BYTE, data: RESET_BYTE,
                   shift: RESET_BYTE, state: LINK_IDLE, cnt: 3'h0,
                   scl_s1: 1'b1, scl_s2: 1'b1, scl_prev: 1'b1,
                   sda_s1: 1'b1, sda_s2: 1'b1, sda_prev: 1'b1,
                   waitreq: 1'b1, readdata: 32'h00000000,
                   default: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign AVS_READDATA = s.readdata;
    assign AVS_WAITREQUEST = s.waitreq;
    assign SCL_OUT = s.line_level;
    assign SDA_OUT = s.line_level;
    assign SCL_OE = s.scl_oe;
    assign SDA_OE = s.sda_oe;
    assign START_ISSUE = s.start_issue;
    assign WAKE_REQUEST = s.wake;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    a_status_no_info: assert property (
        !s.irq_flag |-> (status_view(s) & STATUS_CODE_MASK) == ST_NO_INFO)
        else $error("status not F8 while flag clear");

    a_stretch_held: assert property (
        (s.state == LINK_WAIT && s.irq_flag) |-> SCL_OE)
        else $error("clock not held while flag set");

    a_addr_read_code: assert property (
        (s.state == LINK_ADDR_ACK && s.acking && scl_fall && !start_cond
         && !stop_cond && s.iface_enable && !ARB_LOST)
        |=> s.irq_flag && s.code == ST_OWN_READ && SCL_OE && !SDA_OE)
        else $error("own read address not reported as A8");

    a_arb_read_code: assert property (
        (s.state == LINK_ADDR_ACK && s.acking && scl_fall && !start_cond
         && !stop_cond && s.iface_enable && ARB_LOST)
        |=> s.irq_flag && s.code == ST_ARB_READ)
        else $error("arbitration read not reported as B0");

    a_nack_code: assert property (
        (s.state == LINK_TX_ACK_END && scl_fall && !s.ack_seen
         && !start_cond && !stop_cond && s.iface_enable)
        |=> s.code == ST_DATA_NACK && s.irq_flag)
        else $error("master NACK not reported as C0");

    a_last_ack_code: assert property (
        (s.state == LINK_TX_ACK_END && scl_fall && s.ack_seen && s.last
         && !start_cond && !stop_cond && s.iface_enable)
        |=> s.code == ST_LAST_ACK)
        else $error("ack after final byte not reported as C8");

    a_data_ack_code: assert property (
        (s.state == LINK_TX_ACK_END && scl_fall && s.ack_seen && !s.last
         && !start_cond && !stop_cond && s.iface_enable)
        |=> s.code == ST_DATA_ACK)
        else $error("acked data byte not reported as B8");

    a_ignore_released: assert property (
        (s.state == LINK_IGNORE)[*2] |-> !SDA_OE)
        else $error("data line driven while not addressed");

    a_data_when_low: assert property (
        (s.state == LINK_TX && $changed(SDA_OE)) |-> !s.scl_s2)
        else $error("data changed while clock high");

    a_no_ack_disabled: assert property (
        (s.state == LINK_ADDR && scl_rise && s.cnt == LAST_BIT
         && !s.ack_enable && !start_cond && !stop_cond)
        |=> s.state != LINK_ADDR_ACK)
        else $error("address acknowledged with ack_enable low");

    a_wake_holds: assert property (
        WAKE_REQUEST |-> SCL_OE && s.irq_flag && !s.deep_sleep)
        else $error("wake without clock hold");

    a_last_flag: assert property (
        (s.state == LINK_WAIT && !s.irq_flag && !s.ack_enable
         && s.code != ST_DATA_NACK && s.code != ST_LAST_ACK
         && !start_cond && !stop_cond && s.iface_enable)
        |=> s.last && s.state == LINK_TX)
        else $error("final byte not marked with ack_enable low");

    a_start_pending: assert property (
        (s.start_pending && !s.busy) |=> START_ISSUE && !s.start_pending)
        else $error("start not issued on free bus");

endmodule : two_wire_slave_transmitter
`default_nettype wire

// ---- testbench/bus_master_receiver.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_master_receiver (
    output logic SCL_DRIVE,
    output logic SDA_DRIVE,
    input wire logic SCL_LINE,
    input wire logic SDA_LINE
);
    integer stalls = 0;
    initial begin
        SCL_DRIVE = 1'b1;
        SDA_DRIVE = 1'b1;
    end
    // Data moves only in the low phase; sampled mid-way through the high phase
    task automatic bit_cycle(input logic b, output logic r);
        integer n;
        #20 SDA_DRIVE = b;
        #43 SCL_DRIVE = 1'b1;
        n = 0;
        // Slave may stretch the clock; a stuck line must not hang the run
        while (SCL_LINE !== 1'b1 && n < 20000) begin
            #10 n = n + 1;
        end
        if (n >= 20000) stalls = stalls + 1;
        #31 r = SDA_LINE;
        #31 SCL_DRIVE = 1'b0;
    endtask : bit_cycle
    task automatic byte_cycle(input logic [7:0] tx, input logic last,
                              output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i], rx[i]);
        end
        bit_cycle(last, ack);
    endtask : byte_cycle
    task automatic start_cond();
        #20 SDA_DRIVE = 1'b1;
        #20 SCL_DRIVE = 1'b1;
        #62 SDA_DRIVE = 1'b0;
        #62 SCL_DRIVE = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #20 SDA_DRIVE = 1'b0;
        #42 SCL_DRIVE = 1'b1;
        #62 SDA_DRIVE = 1'b1;
        #62;
    endtask : stop_cond
endmodule : bus_master_receiver
`default_nettype wire

// ---- testbench/two_wire_slave_transmitter_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_transmitter_tb;
    import two_wire_slave_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic arb_lost = 1'b0;
    avalon_req_type req = '0;
    logic [31:0] rdata;
    logic wait_req, scl_oe, sda_oe, start_issue, wake, scl_m, sda_m;
    logic scl_out, sda_out;
    // Open-drain lines with pull-ups; the driven level must really be low
    wire logic scl_w = scl_m & (scl_out | ~scl_oe);
    wire logic sda_w = sda_m & (sda_out | ~sda_oe);
    integer num_errors = 0, check_count = 0, start_cnt = 0, wake_cnt = 0;
    logic [31:0] seed = 32'h0c9881d9;
    logic [7:0] tx_q[$];
    always #5 clock = ~clock;
    always @(posedge clock) begin
        if (start_issue === 1'b1)
            start_cnt <= start_cnt + 1;
        if (wake === 1'b1)
            wake_cnt <= wake_cnt + 1;
    end
    two_wire_slave_transmitter i_dut (.CLOCK(clock), .RST_B(rst_b),
        .AVS_REQ(req), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .SCL_IN(scl_w), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_w),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ARB_LOST(arb_lost),
        .START_ISSUE(start_issue), .WAKE_REQUEST(wake));
    bus_master_receiver i_master (.SCL_DRIVE(scl_m), .SDA_DRIVE(sda_m),
        .SCL_LINE(scl_w), .SDA_LINE(sda_w));
    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd8
    task automatic wrap_up();
        num_errors = num_errors + i_master.stalls;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic check8(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic av(input logic wr, input logic [2:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
        integer n;
        @(posedge clock);
        req <= '{read: !wr, write: wr, address: idx,
                 writedata: {24'h0, wd}, byteenable: 4'hf};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (n >= 50) num_errors++;
        rd = rdata[7:0];
        req <= '0;
    endtask : av
    task automatic wait_flag(input logic [7:0] code);
        integer n;
        logic [7:0] r;
        n = 0;
        r = 8'h00;
        while (r[CTRL_IRQ_FLAG] !== 1'b1 && n < 100) begin
            av(1'b0, IDX_CONTROL, 8'h00, r);
            n++;
        end
        if (n >= 100) num_errors++;
        check8(8'h01, {7'h0, scl_oe});
        av(1'b0, IDX_STATUS, 8'h00, r);
        check8(code, r & STATUS_CODE_MASK);
    endtask : wait_flag
    task automatic address(input logic [6:0] a, input logic acked,
                           input logic [7:0] code);
        logic [7:0] rx;
        logic ack;
        i_master.start_cond();
        i_master.byte_cycle({a, 1'b1}, 1'b1, rx, ack);
        check8({7'h0, !acked}, {7'h0, ack});
        if (acked)
            wait_flag(code);
        else
            i_master.stop_cond();
    endtask : address
    task automatic send_one(input logic last, input logic m_ack);
        logic [7:0] d, r, rx;
        logic a;
        d = rnd8();
        tx_q.push_back(d);
        av(1'b1, IDX_DATA, d, r);
        av(1'b1, IDX_CONTROL, last ? 8'h84 : 8'hc4, r);
        i_master.byte_cycle(8'hff, !m_ack, rx, a);
        check8(tx_q.pop_front(), rx);
        wait_flag(!m_ack ? ST_DATA_NACK : last ? ST_LAST_ACK : ST_DATA_ACK);
    endtask : send_one
    task automatic done_frame(input logic [7:0] ctrl);
        logic [7:0] r;
        av(1'b1, IDX_CONTROL, ctrl, r);
        av(1'b0, IDX_STATUS, 8'h00, r);
        check8(ST_NO_INFO, r);
        i_master.stop_cond();
    endtask : done_frame
    initial begin
        #900000;
        num_errors++;
        wrap_up();
    end
    initial begin
        logic [7:0] r, rx;
        logic a;
        integer c0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        av(1'b0, IDX_STATUS, 8'h00, r);
        check8(ST_NO_INFO, r);
        av(1'b0, 3'h5, 8'h00, r);
        check8(8'h00, r);
        av(1'b1, IDX_DATA, 8'h5a, r);
        av(1'b0, IDX_CONTROL, 8'h00, r);
        check8(8'h08, r & 8'h08);
        av(1'b1, IDX_OWN_ADDR, 8'ha5, r);
        av(1'b1, IDX_CONTROL, 8'h44, r);
        address(7'h52, 1'b1, ST_OWN_READ);
        send_one(1'b0, 1'b1);
        send_one(1'b0, 1'b1);
        send_one(1'b1, 1'b0);
        done_frame(8'hc4);
        $display("test stream done");
        address(7'h00, 1'b1, ST_OWN_READ);
        send_one(1'b1, 1'b1);
        av(1'b1, IDX_CONTROL, 8'hc4, r);
        i_master.byte_cycle(8'hff, 1'b1, rx, a);
        check8(8'hff, rx);
        i_master.stop_cond();
        $display("test last byte done");
        address(7'h53, 1'b0, 8'h00);
        av(1'b1, IDX_OWN_ADDR, 8'ha4, r);
        address(7'h00, 1'b0, 8'h00);
        av(1'b1, IDX_CONTROL, 8'h04, r);
        address(7'h52, 1'b0, 8'h00);
        av(1'b1, IDX_CONTROL, 8'h44, r);
        address(7'h52, 1'b1, ST_OWN_READ);
        send_one(1'b1, 1'b0);
        c0 = start_cnt;
        done_frame(8'he4);
        check8(8'h01, 8'(start_cnt - c0));
        av(1'b1, IDX_CONTROL, 8'h44, r);
        $display("test recognition done");
        av(1'b1, IDX_STATUS, 8'h03, r);
        @(posedge clock);
        arb_lost <= 1'b1;
        address(7'h52, 1'b1, ST_ARB_READ);
        av(1'b0, IDX_STATUS, 8'h00, r);
        check8(ST_ARB_READ | STATUS_PRESCALE_MASK, r);
        @(posedge clock);
        arb_lost <= 1'b0;
        send_one(1'b1, 1'b0);
        av(1'b1, IDX_STATUS, 8'h00, r);
        done_frame(8'hc4);
        c0 = wake_cnt;
        av(1'b1, IDX_SLEEP, 8'h01, r);
        address(7'h52, 1'b1, ST_OWN_READ);
        check8(8'h01, 8'(wake_cnt - c0));
        av(1'b0, IDX_SLEEP, 8'h00, r);
        check8(8'h00, r);
        send_one(1'b1, 1'b0);
        done_frame(8'hc4);
        $display("test wake done");
        wrap_up();
    end
endmodule : two_wire_slave_transmitter_tb
`default_nettype wire
